// ==== hw/isrp_map.svh ====
// Constants of the two-wire slave register port
`ifndef ISRP_MAP_SVH
`define ISRP_MAP_SVH

// ==========================================================
// Bus addresses selected by the strap pin
`define ISRP_DEV_ADDR_LO 7'h5a
`define ISRP_DEV_ADDR_HI 7'h5b

// ==========================================================
// Byte framing
`define ISRP_DATA_BITS   4'h8
`define ISRP_PTR_W       8
`define ISRP_DATA_W      8

// ==========================================================
// Write buffer
`define ISRP_FIFO_W      16
`define ISRP_FIFO_DEPTH  16

// ==========================================================
// Timing: core clock and fastest bus rate
`define ISRP_CLK_HZ      100000000
`define ISRP_FM_HZ       400000
`define ISRP_FMP_HZ      1000000
// Shortest SCL half period in core cycles, rounded down
`define ISRP_HALF_CYC    (`ISRP_CLK_HZ / (2 * `ISRP_FMP_HZ))

`endif

// ==== hw/isrp_pkg.sv ====
// Types shared by the two-wire slave register port
package isrp_pkg;

    // ==========================================================
    // Bus engine states
    typedef enum logic [2:0]
    {
        st_idle,
        st_rx,
        st_ack,
        st_tx,
        st_mack,
        st_wait
    } isrp_state_t;

    // ==========================================================
    // Meaning of the byte being received
    typedef enum logic [1:0]
    {
        k_addr,
        k_ptr,
        k_data
    } isrp_kind_t;

endpackage

// ==== hw/isrp_stream_if.sv ====
// Valid/ready word stream between the port's own modules
`timescale 1ns/1ps

interface isrp_stream_if
#(
    parameter int W = 16
);
    logic [W-1:0] data;   // Word carried
    logic         valid;  // Source offers a word
    logic         ready;  // Sink takes it

    // Producer side
    modport src
    (
        output data,
        output valid,
        input  ready
    );

    // Consumer side
    modport snk
    (
        input  data,
        input  valid,
        output ready
    );
endinterface

// ==== hw/isrp_sync.sv ====
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module isrp_sync
#(
    parameter int           W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
)
(
    // Clock and reset
    input  wire logic         clock,
    input  wire logic         rst,
    // Raw pins and filtered levels
    input  wire logic [W-1:0] pin,
    output logic      [W-1:0] level
);

    // ==========================================================
    // One chain per bit
    genvar i;
    generate
        for (i = 0; i < W; i++)
        begin : g_bit
            logic s1;  // Metastability catcher, read by s2 only
            logic s2;  // Second stage
            logic s3;  // Third stage

            // Shift chain
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                begin
                    s1 <= RST_VAL[i];
                    s2 <= RST_VAL[i];
                    s3 <= RST_VAL[i];
                end
                else
                begin
                    s1 <= pin[i];
                    s2 <= s1;
                    s3 <= s2;
                end
            end

            // A change counts only once two stages agree
            always_ff @(posedge clock or posedge rst)
            begin
                if (rst)
                    level[i] <= RST_VAL[i];
                else if (s2 == s3)
                    level[i] <= s3;
            end
        end
    endgenerate

endmodule

// ==== hw/isrp_fifo.sv ====
// Flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
`include "isrp_map.svh"

module isrp_fifo
#(
    parameter int W     = `ISRP_FIFO_W,
    parameter int DEPTH = `ISRP_FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic  clock,
    input  wire logic  rst,
    // Filling and draining sides
    isrp_stream_if.snk push,
    isrp_stream_if.src pop
);

    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem [DEPTH];  // Storage
    logic [AW-1:0] wp;          // Write index
    logic [AW-1:0] rp;          // Read index
    logic [AW:0]   count;       // Words held
    logic          do_push;
    logic          do_pop;

    // Honest flags straight from the count
    assign push.ready = (count != (AW+1)'(DEPTH));
    assign pop.valid  = (count != '0);
    assign pop.data   = mem[rp];
    assign do_push    = push.valid && push.ready;
    assign do_pop     = pop.valid && pop.ready;

    // ==========================================================
    // Storage write, no reset needed on data
    always_ff @(posedge clock)
    begin
        if (do_push)
            mem[wp] <= push.data;
    end

    // Indices and fill level
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            wp    <= '0;
            rp    <= '0;
            count <= '0;
        end
        else
        begin
            if (do_push)
                wp <= wp + 1'b1;
            if (do_pop)
                rp <= rp + 1'b1;
            count <= count + (AW+1)'(do_push) - (AW+1)'(do_pop);
        end
    end

    // ==========================================================
    // Checks
    a_fifo_full_block: assert property (
        @(posedge clock) disable iff (rst)
        count == (AW+1)'(DEPTH) |-> !push.ready && pop.valid)
        else $error("fifo accepts while full");

    a_fifo_count_step: assert property (
        @(posedge clock) disable iff (rst)
        do_push && !do_pop |=> count == $past(count) + 1'b1)
        else $error("fifo count did not rise on push");

endmodule

// ==== hw/isrp_i2c_slave.sv ====
// Two-wire bus slave port with pointer and buffered writes
//
// Functional notes
// - Slave only, up to fast mode plus.
// - Strap pin picks between two addresses.
// - Transmitter changes SDA only while SCL low.
// - START/STOP are SDA edges with SCL high.
// - Repeated START behaves exactly as START.
// - Nine clocks per byte, MSB first.
// - Receiver pulls SDA low to acknowledge.
// - No limit on bytes per transaction.
// - First byte is address plus direction flag.
// - Write sends register pointer, device acknowledges.
// - Device acknowledges every byte when written.
// - Written byte stored, pointer then increments.
// - Read returns pointer register, then increments if the master acks.
`timescale 1ns/1ps
`include "isrp_map.svh"

module isrp_i2c_slave
(
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       rst,
    // Two-wire bus, open drain
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe,
    // Address strap
    input  wire logic       addr_sel,
    // Register write stream
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic [7:0]      wr_ptr,
    output logic [7:0]      wr_data,
    // Register read port
    output logic [7:0]      rd_ptr,
    input  wire logic [7:0] rd_data,
    output logic            rd_take,
    // Status
    output logic            busy
);

    // ==========================================================
    // Pin sampling
    logic [2:0] pins_f;    // Filtered {strap, scl, sda}
    logic       scl_f;     // Filtered SCL
    logic       sda_f;     // Filtered SDA
    logic       strap_f;   // Filtered strap
    logic       scl_q;     // SCL one cycle back
    logic       sda_q;     // SDA one cycle back

    // Bus idles high, so the SCL and SDA filter bits start high; the strap bit starts low
    isrp_sync #(.W(3), .RST_VAL(3'h3)) u_sync
    (
        .clock (clock),
        .rst   (rst),
        .pin   ({addr_sel, scl_i, sda_i}),
        .level (pins_f)
    );

    assign strap_f = pins_f[2];
    assign scl_f   = pins_f[1];
    assign sda_f   = pins_f[0];

    // Previous filtered levels for edge finding
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    // ==========================================================
    // Bus events
    logic scl_rise;   // SCL went high
    logic scl_fall;   // SCL went low
    logic start_ev;   // START or repeated START
    logic stop_ev;    // STOP

    assign scl_rise = scl_f && !scl_q;
    assign scl_fall = !scl_f && scl_q;
    // SDA edges with SCL high on both samples
    assign start_ev = scl_f && scl_q && sda_q && !sda_f;
    assign stop_ev  = scl_f && scl_q && !sda_q && sda_f;

    // Own address from the strap
    logic [6:0] own_addr;
    assign own_addr = strap_f ? `ISRP_DEV_ADDR_HI : `ISRP_DEV_ADDR_LO;

    // ==========================================================
    // Engine state
    isrp_pkg::isrp_state_t state;   // Phase of the byte
    isrp_pkg::isrp_kind_t  kind;    // What the byte means
    logic [3:0]            bitcnt;  // Rising edges this byte
    logic [7:0]            shreg;   // Shift register
    logic                  is_read; // Direction flag latched
    logic                  pend;    // Data byte awaiting buffer
    logic [7:0]            ptr;     // Register pointer
    logic                  byte_end;
    logic                  ptr_adv; // Master acked a read byte

    // Eight bits taken, ninth clock comes next
    assign byte_end = scl_fall && (bitcnt == `ISRP_DATA_BITS);

    // ==========================================================
    // Write buffer between bus and register file
    isrp_stream_if #(.W(`ISRP_FIFO_W)) wr_in ();
    isrp_stream_if #(.W(`ISRP_FIFO_W)) wr_out ();

    isrp_fifo #(.W(`ISRP_FIFO_W), .DEPTH(`ISRP_FIFO_DEPTH)) u_fifo
    (
        .clock (clock),
        .rst   (rst),
        .push  (wr_in.snk),
        .pop   (wr_out.src)
    );

    // Store at the current pointer
    assign wr_in.data   = {ptr, shreg};
    assign wr_in.valid  = pend;
    assign wr_out.ready = wr_ready;
    assign wr_valid     = wr_out.valid;
    assign wr_ptr       = wr_out.data[15:8];
    assign wr_data      = wr_out.data[7:0];

    // ==========================================================
    // Main sequencer; START and STOP override any phase
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            state <= isrp_pkg::st_idle;
            kind  <= isrp_pkg::k_addr;
        end
        else if (start_ev)
        begin
            // Repeated START handled like START
            state <= isrp_pkg::st_rx;
            kind  <= isrp_pkg::k_addr;
        end
        else if (stop_ev)
            state <= isrp_pkg::st_idle;
        else
        begin
            unique case (state)
                isrp_pkg::st_idle,
                isrp_pkg::st_wait:
                    // Only START or STOP leaves these
                    state <= state;
                isrp_pkg::st_rx:
                    if (byte_end)
                    begin
                        // Address match decides presence
                        if (kind == isrp_pkg::k_addr &&
                            shreg[7:1] != own_addr)
                            state <= isrp_pkg::st_wait;
                        else
                            state <= isrp_pkg::st_ack;
                    end
                isrp_pkg::st_ack:
                    if (scl_fall)
                    begin
                        // Ninth clock over; choose next phase
                        if (kind == isrp_pkg::k_addr && is_read)
                            state <= isrp_pkg::st_tx;
                        else
                            state <= isrp_pkg::st_rx;
                        if (kind == isrp_pkg::k_addr && !is_read)
                            kind <= isrp_pkg::k_ptr;
                        else
                            kind <= isrp_pkg::k_data;
                    end
                isrp_pkg::st_tx:
                    if (byte_end)
                        state <= isrp_pkg::st_mack;
                isrp_pkg::st_mack:
                    if (scl_fall)
                    begin
                        // Master NACK ends our turn
                        if (ptr_adv)
                            state <= isrp_pkg::st_tx;
                        else
                            state <= isrp_pkg::st_wait;
                    end
            endcase
        end
    end

    // ==========================================================
    // Bit counter, cleared per byte so any length works
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            bitcnt <= '0;
        else if (start_ev || byte_end)
            bitcnt <= '0;
        else if (scl_rise && (state == isrp_pkg::st_rx ||
                              state == isrp_pkg::st_tx))
            bitcnt <= bitcnt + 1'b1;
        else if (scl_fall && state == isrp_pkg::st_ack)
            bitcnt <= '0;
    end

    // ==========================================================
    // Shift register: MSB first both ways
    logic load_tx;   // Fetch a byte for the master
    assign load_tx = scl_fall &&
        ((state == isrp_pkg::st_ack && kind == isrp_pkg::k_addr &&
          is_read) || (state == isrp_pkg::st_mack && ptr_adv));
    assign rd_take = load_tx;
    assign rd_ptr  = ptr;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            shreg <= '0;
        else if (load_tx)
            shreg <= rd_data;
        else if (state == isrp_pkg::st_rx && scl_rise)
            shreg <= {shreg[6:0], sda_f};
        else if (state == isrp_pkg::st_tx && scl_fall && !byte_end)
            // Shift only after SCL falls
            shreg <= {shreg[6:0], 1'b0};
    end

    // Direction flag of the address byte
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            is_read <= 1'b0;
        else if (state == isrp_pkg::st_rx && byte_end &&
                 kind == isrp_pkg::k_addr)
            is_read <= shreg[0];
    end

    // ==========================================================
    // Pending write: SCL is stretched while buffer is full
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pend <= 1'b0;
        else if (state == isrp_pkg::st_rx && byte_end &&
                 kind == isrp_pkg::k_data)
            pend <= 1'b1;
        else if (wr_in.ready)
            pend <= 1'b0;
    end

    // ==========================================================
    // Pointer: loaded by the pointer byte, bumped after each buffered write byte and each master-acked read byte
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ptr_adv <= 1'b0;
        else if (state == isrp_pkg::st_mack && scl_rise)
            ptr_adv <= !sda_f;
        else if (state != isrp_pkg::st_mack)
            ptr_adv <= 1'b0;
    end

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            ptr <= '0;
        else if (state == isrp_pkg::st_rx && byte_end &&
                 kind == isrp_pkg::k_ptr)
            ptr <= shreg;
        else if (pend && wr_in.ready)
            ptr <= ptr + 1'b1;
        else if (state == isrp_pkg::st_mack && scl_rise && !sda_f)
            ptr <= ptr + 1'b1;
    end

    // ==========================================================
    // Open-drain drive; only ever pulls low
    assign sda_o  = 1'b0;
    assign scl_o  = 1'b0;
    // Hold SCL low rather than drop a byte when buffer fills
    assign scl_oe = pend;
    // ACK low on ninth clock, data bit while sending
    assign sda_oe = (state == isrp_pkg::st_ack) ||
                    (state == isrp_pkg::st_tx && !shreg[7]);
    assign busy   = (state != isrp_pkg::st_idle);

    // ==========================================================
    // Checks
    a_sda_stable_high: assert property (
        @(posedge clock) disable iff (rst)
        scl_f && scl_q && !start_ev && !stop_ev
            |-> $stable(sda_oe))
        else $error("SDA drive changed while SCL high");

    a_addr_match_ack: assert property (
        @(posedge clock) disable iff (rst)
        state == isrp_pkg::st_rx && kind == isrp_pkg::k_addr &&
        byte_end && shreg[7:1] == own_addr && !start_ev && !stop_ev
            |=> state == isrp_pkg::st_ack && sda_oe)
        else $error("own address not acknowledged");

    a_foreign_release: assert property (
        @(posedge clock) disable iff (rst)
        state == isrp_pkg::st_wait |-> !sda_oe && !scl_oe)
        else $error("bus driven for foreign address");

    a_start_rearms: assert property (
        @(posedge clock) disable iff (rst)
        start_ev |=> state == isrp_pkg::st_rx &&
            kind == isrp_pkg::k_addr && bitcnt == 4'h0)
        else $error("START did not rearm address phase");

    a_stop_goes_idle: assert property (
        @(posedge clock) disable iff (rst)
        stop_ev && !start_ev |=> state == isrp_pkg::st_idle)
        else $error("STOP did not free the port");

    a_nine_clocks: assert property (
        @(posedge clock) disable iff (rst)
        state == isrp_pkg::st_rx && byte_end && !start_ev && !stop_ev
            |=> state != isrp_pkg::st_rx && bitcnt == 4'h0)
        else $error("byte did not end after eight bits");

    a_write_advance: assert property (
        @(posedge clock) disable iff (rst)
        pend && wr_in.ready |=> ptr == $past(ptr) + 8'h01 &&
            !pend)
        else $error("pointer not advanced after write");

    a_read_advance: assert property (
        @(posedge clock) disable iff (rst)
        state == isrp_pkg::st_mack && scl_rise && !sda_f
            |=> ptr == $past(ptr) + 8'h01 && ptr_adv)
        else $error("pointer not advanced after read ack");

    a_ptr_loaded: assert property (
        @(posedge clock) disable iff (rst)
        state == isrp_pkg::st_rx && kind == isrp_pkg::k_ptr &&
        byte_end ##1 !start_ev
            |-> ptr == $past(shreg) && sda_oe)
        else $error("pointer byte not taken");

endmodule

// ==== test/isrp_master_model.sv ====
// Behavioural two-wire bus master facing the slave port
`timescale 1ns/1ps

module isrp_master_model
#(
    parameter int HALF = 8  // Core cycles per SCL half period
)
(
    // Core clock
    input  wire logic clock,
    // Resolved bus lines
    input  wire logic scl,
    input  wire logic sda,
    // Pull-down requests of this master
    output logic      scl_low,
    output logic      sda_low
);
    // ==========================================================
    // Bus idle: both lines left to the pull-ups
    initial
    begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    // Wait whole core cycles
    task automatic tk(input int n);
        repeat (n) @(posedge clock);
    endtask

    // ==========================================================
    // One bit; the slave may stretch SCL, so the wait is bounded
    task automatic bit_io(input logic b, output logic r);
        int w;
        tk(2);
        sda_low <= ~b;
        tk(HALF);
        scl_low <= 1'b0;
        w = 0;
        while (scl !== 1'b1 && w < 2000)
        begin
            tk(1);
            w++;
        end
        tk(HALF);
        r = sda;
        scl_low <= 1'b1;
    endtask

    // START or repeated START, SDA falls with SCL high
    task automatic start();
        tk(2);
        sda_low <= 1'b0;
        tk(HALF);
        scl_low <= 1'b0;
        tk(HALF);
        sda_low <= 1'b1;
        tk(HALF);
        scl_low <= 1'b1;
    endtask

    // STOP, SDA rises with SCL high
    task automatic stop();
        tk(2);
        sda_low <= 1'b1;
        tk(HALF);
        scl_low <= 1'b0;
        tk(HALF);
        sda_low <= 1'b0;
        tk(HALF);
    endtask

    // ==========================================================
    // Send a byte MSB first, then read the slave's answer
    task automatic tx(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r);
        bit_io(1'b1, r);
        ack = ~r;
    endtask

    // Receive a byte; NACK marks the last wanted byte
    task automatic rx(input logic ack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(~ack, r);
    endtask
endmodule

// ==== test/tb_isrp_i2c_slave.sv ====
// Self-checking bench of the two-wire slave register port
`timescale 1ns/1ps

`define CHK(n, e, g) \
    begin \
        check_count++; \
        if ((g) !== (e)) \
        begin \
            err_count++; \
            $display("[FAIL] %s exp %h got %h", n, e, g); \
        end \
    end

module tb_isrp_i2c_slave;
    // ==========================================================
    // Design pins
    logic       clock;
    logic       rst;
    logic       addr_sel;
    logic       wr_ready;
    logic       scl_oe;
    logic       sda_oe;
    logic       wr_valid;
    logic [7:0] wr_ptr;
    logic [7:0] wr_data;
    logic [7:0] rd_ptr;
    logic [7:0] rd_data;
    logic       busy;
    logic       scl_o;
    logic       sda_o;
    logic       rd_take;
    // Open-drain wire and master pulls
    wire        scl;
    wire        sda;
    logic       m_scl_low;
    logic       m_sda_low;
    // Register image behind the port
    logic [7:0] mem [256];
    int         err_count;
    int         check_count;
    int         cyc;
    int         sc;
    int         rt;

    // Pull-ups: a line is low while any party pulls it
    assign scl = (scl_oe ? scl_o : 1'b1) & ~m_scl_low;
    assign sda = (sda_oe ? sda_o : 1'b1) & ~m_sda_low;
    // Read data returned in the same cycle
    assign rd_data = mem[rd_ptr];

    isrp_i2c_slave u_dut
    (
        .clock    (clock),
        .rst      (rst),
        .scl_i    (scl),
        .scl_o    (scl_o),
        .scl_oe   (scl_oe),
        .sda_i    (sda),
        .sda_o    (sda_o),
        .sda_oe   (sda_oe),
        .addr_sel (addr_sel),
        .wr_valid (wr_valid),
        .wr_ready (wr_ready),
        .wr_ptr   (wr_ptr),
        .wr_data  (wr_data),
        .rd_ptr   (rd_ptr),
        .rd_data  (rd_data),
        .rd_take  (rd_take),
        .busy     (busy)
    );

    isrp_master_model u_m
    (
        .clock   (clock),
        .scl     (scl),
        .sda     (sda),
        .scl_low (m_scl_low),
        .sda_low (m_sda_low)
    );

    // ==========================================================
    // Clock, register sink, stretch counter and hang guard
    always #5 clock = ~clock;

    always @(posedge clock)
    begin
        if (wr_valid === 1'b1 && wr_ready)
            mem[wr_ptr] <= wr_data;
        if (scl_oe === 1'b1)
            sc++;
        if (rd_take === 1'b1)
            rt++;
        cyc++;
        if (cyc == 40000)
        begin
            err_count++;
            end_of_test();
        end
    end

    // Verdict, printed once
    task automatic end_of_test();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ==========================================================
    // Pointer then two data bytes land in consecutive registers
    task automatic t_write();
        logic a;
        u_m.start();
        `CHK("busy", 1'b1, busy)
        u_m.tx(8'hb4, a);
        `CHK("ack addr", 1'b1, a)
        u_m.tx(8'h10, a);
        `CHK("ack ptr", 1'b1, a)
        u_m.tx(8'hab, a);
        `CHK("ack d0", 1'b1, a)
        u_m.tx(8'hcd, a);
        u_m.stop();
        u_m.tk(8);
        `CHK("idle", 1'b0, busy)
        `CHK("mem10", 8'hab, mem[8'h10])
        `CHK("mem11", 8'hcd, mem[8'h11])
    endtask

    // Pointer set, repeated START, three reads, last one NACKed
    task automatic t_read_sr();
        logic       a;
        logic [7:0] d;
        rt = 0;
        u_m.start();
        u_m.tx(8'hb4, a);
        u_m.tx(8'h10, a);
        u_m.start();
        `CHK("busy sr", 1'b1, busy)
        u_m.tx(8'hb5, a);
        `CHK("ack rd", 1'b1, a)
        u_m.rx(1'b1, d);
        `CHK("rd0", 8'hab, d)
        u_m.rx(1'b1, d);
        `CHK("rd1", 8'hcd, d)
        u_m.rx(1'b0, d);
        `CHK("rd2", 8'h12 ^ 8'h3c, d)
        u_m.stop();
        u_m.tk(8);
        `CHK("released", 1'b0, busy)
        `CHK("takes", 3, rt)
    endtask

    // Strap high: old address ignored, pointer wraps on read
    task automatic t_addr();
        logic       a;
        logic [7:0] d;
        addr_sel <= 1'b1;
        u_m.tk(8);
        u_m.start();
        u_m.tx(8'hb4, a);
        `CHK("foreign", 1'b0, a)
        u_m.tx(8'h00, a);
        `CHK("ignored", 1'b0, a)
        u_m.stop();
        u_m.start();
        u_m.tx(8'hb6, a);
        `CHK("ack hi", 1'b1, a)
        u_m.tx(8'hff, a);
        u_m.stop();
        u_m.start();
        u_m.tx(8'hb7, a);
        u_m.rx(1'b1, d);
        `CHK("rd ff", 8'hff ^ 8'h3c, d)
        u_m.rx(1'b0, d);
        `CHK("rd wrap", 8'h3c, d)
        u_m.stop();
    endtask

    // Seventeen bytes with the sink stalled: buffer fills, SCL held
    task automatic t_fifo();
        logic a;
        wr_ready <= 1'b0;
        u_m.start();
        u_m.tx(8'hb6, a);
        u_m.tx(8'h40, a);
        for (int i = 0; i < 16; i++)
        begin
            u_m.tx(8'h80 + 8'(i), a);
            `CHK("ack fill", 1'b1, a)
        end
        `CHK("head", 16'h4080, {wr_ptr, wr_data})
        sc = 0;
        fork
            u_m.tx(8'h90, a);
            begin
                u_m.tk(400);
                wr_ready <= 1'b1;
            end
        join
        `CHK("ack full", 1'b1, a)
        `CHK("stretch", 1'b1, sc > 100)
        u_m.stop();
        u_m.tk(40);
        `CHK("drained", 1'b0, wr_valid)
        for (int i = 0; i < 17; i++)
            `CHK("fifo mem", 8'h80 + 8'(i), mem[8'h40 + 8'(i)])
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        clock = 1'b0;
        rst = 1'b1;
        addr_sel = 1'b0;
        wr_ready = 1'b1;
        err_count = 0;
        check_count = 0;
        cyc = 0;
        sc = 0;
        rt = 0;
        for (int i = 0; i < 256; i++)
            mem[i] = 8'(i) ^ 8'h3c;
        repeat (8) @(posedge clock);
        `CHK("rst", 5'h00, {scl_oe, sda_oe, busy, rd_take, wr_valid})
        rst <= 1'b0;
        repeat (8) @(posedge clock);
        t_write();
        t_read_sr();
        t_addr();
        t_fifo();
        end_of_test();
    end
endmodule
